// File: rtl/sbsc_config_regs.sv
`timescale 1ns/10ps
module sbsc_config_regs #(
    parameter logic [7:0][27:0] IVL_CYC = sbsc_pkg::IVL_CYC_DEF
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic current_channel_silence_out,
    output logic voltage_channel_silence_out,
    output logic [1:0] sense_range_select_out,
    output logic boost_level_scheme_out,
    output logic [2:0] monitor_adc_interval_out,
    output logic readback_freeze_out,
    output logic [1:0] monitor_adc_scan_kind_out,
    output logic monitor_adc_power_out,
    input wire logic dsp_trigger_in,
    input wire logic conv_done_in,
    input wire logic [9:0] conv_data_in,
    output logic conv_start_out,
    output logic [9:0] readback_data_out
);
    ////////////////////////////////////////////////////////////////
    // register storage behind the control port
    sbsc_reg_if rif ();

    assign rif.wr_en = reg_wr_in;
    assign rif.addr = reg_addr_in;
    assign rif.wdata = reg_wdata_in;

    sbsc_reg_store u_store (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .rif(rif.store)
    );

    // true when an access lands on a given offset of this page
    function automatic logic cfg_hit(
        input logic [7:0] page,
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return page == sbsc_pkg::CFG_PAGE && addr == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////
    // field taps; every one comes straight off a stored flop
    assign current_channel_silence_out = rif.mute_q[sbsc_pkg::ISIL_BIT];
    assign voltage_channel_silence_out = rif.mute_q[sbsc_pkg::VSIL_BIT];
    assign sense_range_select_out = rif.range_q[sbsc_pkg::RANGE_LSB +: 2];
    assign boost_level_scheme_out = rif.boost_q[sbsc_pkg::BOOST_BIT];
    assign monitor_adc_interval_out = rif.scan_q[sbsc_pkg::IVL_LSB +: 3];
    assign readback_freeze_out = rif.scan_q[sbsc_pkg::FRZ_BIT];
    assign monitor_adc_scan_kind_out = rif.scan_q[sbsc_pkg::KIND_LSB +: 2];
    assign monitor_adc_power_out = rif.scan_q[sbsc_pkg::PWR_BIT];

    ////////////////////////////////////////////////////////////////
    // one-shot arming: a write of the scan register with power on and
    // one-shot mode arms one conversion; armed a cycle late so the
    // timer sees the new mode and power already in place
    wire wr_scan = reg_wr_in && cfg_hit(rif.page_q, reg_addr_in, sbsc_pkg::SCAN_OFS);
    wire [1:0] wr_kind = reg_wdata_in[sbsc_pkg::KIND_LSB +: 2];
    wire arm_d = wr_scan && reg_wdata_in[sbsc_pkg::PWR_BIT]
        && wr_kind == sbsc_pkg::SBSC_ONE_SHOT;
    logic arm_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) arm_q <= 1'b0;
        else arm_q <= arm_d;
    end

    // conversion scheduler
    sbsc_scan_timer #(
        .IVL_CYC(IVL_CYC)
    ) u_timer (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .power_in(monitor_adc_power_out),
        .kind_in(sbsc_pkg::sbsc_kind_e'(monitor_adc_scan_kind_out)),
        .ivl_in(monitor_adc_interval_out),
        .arm_in(arm_q),
        .trig_in(dsp_trigger_in),
        .done_in(conv_done_in),
        .start_out(conv_start_out)
    );

    ////////////////////////////////////////////////////////////////
    // readback holding register; frozen so a multi-byte read cannot
    // tear, at the price of losing results taken meanwhile
    wire rb_load = conv_done_in && !readback_freeze_out;
    logic [9:0] rb_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) rb_q <= 10'h000;
        else if (rb_load) rb_q <= conv_data_in;
    end

    assign readback_data_out = rb_q;

    ////////////////////////////////////////////////////////////////
    // read decode; the page selector reads on every page, other offsets of other pages and unmapped offsets read as zero
    wire rd_page = reg_addr_in == sbsc_pkg::PAGE_OFS;
    wire rd_mute = cfg_hit(rif.page_q, reg_addr_in, sbsc_pkg::MUTE_OFS);
    wire rd_range = cfg_hit(rif.page_q, reg_addr_in, sbsc_pkg::RANGE_OFS);
    wire rd_boost = cfg_hit(rif.page_q, reg_addr_in, sbsc_pkg::BOOST_OFS);
    wire rd_scan = cfg_hit(rif.page_q, reg_addr_in, sbsc_pkg::SCAN_OFS);
    wire [7:0] rdata_d = rd_page ? rif.page_q
        : rd_mute ? rif.mute_q
        : rd_range ? rif.range_q
        : rd_boost ? rif.boost_q
        : rd_scan ? rif.scan_q
        : 8'h00;
    logic [7:0] rdata_q;
    logic rvalid_q;

    // read data registered one cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_in;
            if (reg_rd_in) rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence seq_wr(logic [7:0] ofs);
        reg_wr_in && rif.page_q == sbsc_pkg::CFG_PAGE && reg_addr_in == ofs;
    endsequence

    sequence seq_rd(logic [7:0] ofs);
        reg_rd_in && rif.page_q == sbsc_pkg::CFG_PAGE && reg_addr_in == ofs;
    endsequence

    sequence seq_kind_rsvd;
        monitor_adc_scan_kind_out == 2'h3 ##1 monitor_adc_scan_kind_out == 2'h3;
    endsequence

    sequence seq_power_off;
        !monitor_adc_power_out ##1 !monitor_adc_power_out;
    endsequence

    a_cur_silence: assert property (
        seq_wr(sbsc_pkg::MUTE_OFS) |=>
            current_channel_silence_out == $past(reg_wdata_in[1]))
        else $error("current silence did not follow write");

    a_volt_silence: assert property (
        seq_wr(sbsc_pkg::MUTE_OFS) |=>
            voltage_channel_silence_out == $past(reg_wdata_in[0]))
        else $error("voltage silence did not follow write");

    a_range_select: assert property (
        seq_wr(sbsc_pkg::RANGE_OFS) |=>
            sense_range_select_out == $past(reg_wdata_in[2:1]))
        else $error("sense range did not follow write");

    a_boost_scheme: assert property (
        seq_wr(sbsc_pkg::BOOST_OFS) |=>
            boost_level_scheme_out == $past(reg_wdata_in[0]))
        else $error("boost scheme did not follow write");

    a_interval_code: assert property (
        seq_wr(sbsc_pkg::SCAN_OFS) |=>
            monitor_adc_interval_out == $past(reg_wdata_in[6:4])
            && monitor_adc_scan_kind_out == $past(reg_wdata_in[2:1]))
        else $error("interval or mode did not follow write");

    a_freeze_hold: assert property (
        readback_freeze_out && conv_done_in |=> $stable(readback_data_out))
        else $error("readback changed while frozen");

    a_live_update: assert property (
        !readback_freeze_out && conv_done_in |=>
            readback_data_out == $past(conv_data_in))
        else $error("readback missed a conversion");

    a_power_gate: assert property (
        seq_power_off |-> !conv_start_out)
        else $error("conversion started while powered down");

    a_repeat_launch: assert property (
        monitor_adc_power_out && monitor_adc_scan_kind_out == 2'h1
            && !conv_start_out ##1 conv_done_in |-> ##[1:2] conv_start_out
            or (!monitor_adc_power_out || monitor_adc_interval_out != 3'h0))
        else $error("repeated scan did not relaunch");

    a_scan_reset: assert property (
        $rose(rstn_in) |-> rif.scan_q == sbsc_pkg::SCAN_RST)
        else $error("scan register reset value wrong");

    a_low_reset: assert property (
        $rose(rstn_in) |-> rif.mute_q == sbsc_pkg::MUTE_RST
            && rif.range_q == sbsc_pkg::RANGE_RST
            && rif.boost_q == sbsc_pkg::BOOST_RST)
        else $error("low bank reset value wrong");

    a_page_gate: assert property (
        reg_wr_in && rif.page_q != sbsc_pkg::CFG_PAGE
            && reg_addr_in != sbsc_pkg::PAGE_OFS |=>
            $stable(rif.mute_q) && $stable(rif.scan_q))
        else $error("write reached the bank from another page");

    a_reserved_rb: assert property (
        seq_wr(sbsc_pkg::MUTE_OFS) ##1 !reg_wr_in ##1 seq_rd(sbsc_pkg::MUTE_OFS)
            |=> reg_rvalid_out && reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("mute byte did not read back as written");

    // stored bytes only move on a write that reaches them
    a_mute_hold: assert property (
        !(reg_wr_in && reg_addr_in == sbsc_pkg::MUTE_OFS) |=> $stable(rif.mute_q))
        else $error("mute byte changed without a write");

    a_range_hold: assert property (
        !(reg_wr_in && reg_addr_in == sbsc_pkg::RANGE_OFS) |=> $stable(rif.range_q))
        else $error("range byte changed without a write");

    a_boost_hold: assert property (
        !(reg_wr_in && reg_addr_in == sbsc_pkg::BOOST_OFS) |=> $stable(rif.boost_q))
        else $error("boost byte changed without a write");

    a_scan_hold: assert property (
        !(reg_wr_in && reg_addr_in == sbsc_pkg::SCAN_OFS) |=> $stable(rif.scan_q))
        else $error("scan byte changed without a write");

    a_range_rb: assert property (
        seq_rd(sbsc_pkg::RANGE_OFS) |=> reg_rdata_out == $past(rif.range_q))
        else $error("range byte read back wrong");

    a_boost_rb: assert property (
        seq_rd(sbsc_pkg::BOOST_OFS) |=> reg_rdata_out == $past(rif.boost_q))
        else $error("boost byte read back wrong");

    a_scan_rb: assert property (
        seq_rd(sbsc_pkg::SCAN_OFS) |=> reg_rdata_out == $past(rif.scan_q))
        else $error("scan byte read back wrong");

    a_rvalid_on: assert property (
        reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered next cycle");

    a_rvalid_off: assert property (
        !reg_rd_in |=> !reg_rvalid_out)
        else $error("read valid without a read");

    a_other_page: assert property (
        reg_rd_in && rif.page_q != sbsc_pkg::CFG_PAGE
            && reg_addr_in != sbsc_pkg::PAGE_OFS |=> reg_rdata_out == 8'h00)
        else $error("hidden page did not read as zero");

    a_page_write: assert property (
        reg_wr_in && reg_addr_in == sbsc_pkg::PAGE_OFS |=>
            rif.page_q == $past(reg_wdata_in))
        else $error("page selector did not take the write");

    a_start_pulse: assert property (
        conv_start_out |=> !conv_start_out)
        else $error("start held longer than one cycle");

    a_rsvd_kind: assert property (
        seq_kind_rsvd |-> !conv_start_out)
        else $error("reserved mode started a conversion");
endmodule

// File: rtl/sbsc_pkg.sv
package sbsc_pkg;
    // register offsets within book 0
    localparam logic [7:0] PAGE_OFS = 8'h00;
    localparam logic [7:0] MUTE_OFS = 8'h07;
    localparam logic [7:0] RANGE_OFS = 8'h08;
    localparam logic [7:0] BOOST_OFS = 8'h09;
    localparam logic [7:0] SCAN_OFS = 8'h14;
    // the page on which this bank lives
    localparam logic [7:0] CFG_PAGE = 8'h00;

    // reset values
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] MUTE_RST = 8'h00;
    localparam logic [7:0] RANGE_RST = 8'h00;
    localparam logic [7:0] BOOST_RST = 8'h00;
    localparam logic [7:0] SCAN_RST = 8'h32;

    // field positions
    localparam int unsigned VSIL_BIT = 0;
    localparam int unsigned ISIL_BIT = 1;
    localparam int unsigned RANGE_LSB = 1;
    localparam int unsigned BOOST_BIT = 0;
    localparam int unsigned PWR_BIT = 0;
    localparam int unsigned KIND_LSB = 1;
    localparam int unsigned FRZ_BIT = 3;
    localparam int unsigned IVL_LSB = 4;

    // monitor converter operating modes
    typedef enum logic [1:0] {
        SBSC_ONE_SHOT,
        SBSC_REPEAT,
        SBSC_DSP_TRIG,
        SBSC_KIND_RSVD
    } sbsc_kind_e;

    // repeat interval times, each in its own unit
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned IVL0_US = 0;
    localparam int unsigned IVL1_US = 50;
    localparam int unsigned IVL2_US = 250;
    localparam int unsigned IVL3_MS = 1;
    localparam int unsigned IVL4_MS = 5;
    localparam int unsigned IVL5_MS = 25;
    localparam int unsigned IVL6_MS = 100;
    localparam int unsigned IVL7_S = 1;
    localparam int unsigned CNT_W = 28;

    // microseconds to clock cycles, never below one cycle
    function automatic logic [27:0] us_to_cyc(input int unsigned us);
        int unsigned c;
        c = us * CLK_MHZ;
        if (c == 0) begin
            c = 1;
        end
        return c[27:0];
    endfunction

    localparam logic [7:0][27:0] IVL_CYC_DEF = {
        us_to_cyc(IVL7_S * 1000000), us_to_cyc(IVL6_MS * 1000),
        us_to_cyc(IVL5_MS * 1000), us_to_cyc(IVL4_MS * 1000),
        us_to_cyc(IVL3_MS * 1000), us_to_cyc(IVL2_US),
        us_to_cyc(IVL1_US), us_to_cyc(IVL0_US)};
endpackage

// File: rtl/sbsc_reg_if.sv
`timescale 1ns/10ps
// write strobe toward the store and register contents back
interface sbsc_reg_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] page_q;
    logic [7:0] mute_q;
    logic [7:0] range_q;
    logic [7:0] boost_q;
    logic [7:0] scan_q;

    modport host (
        output wr_en, addr, wdata,
        input page_q, mute_q, range_q, boost_q, scan_q
    );
    modport store (
        input wr_en, addr, wdata,
        output page_q, mute_q, range_q, boost_q, scan_q
    );
endinterface

// File: rtl/sbsc_reg_store.sv
`timescale 1ns/10ps
module sbsc_reg_store (
    input wire logic clk_in,
    input wire logic rstn_in,
    sbsc_reg_if.store rif
);
    ////////////////////////////////////////////////////////////////
    // write decode: the page selector answers on every page
    wire page_hit = rif.page_q == sbsc_pkg::CFG_PAGE;
    wire wr_page = rif.wr_en && rif.addr == sbsc_pkg::PAGE_OFS;
    wire wr_cfg = rif.wr_en && page_hit;
    wire wr_mute = wr_cfg && rif.addr == sbsc_pkg::MUTE_OFS;
    wire wr_range = wr_cfg && rif.addr == sbsc_pkg::RANGE_OFS;
    wire wr_boost = wr_cfg && rif.addr == sbsc_pkg::BOOST_OFS;
    wire wr_scan = wr_cfg && rif.addr == sbsc_pkg::SCAN_OFS;

    ////////////////////////////////////////////////////////////////
    // whole bytes are stored so reserved bits read back as written
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rif.page_q <= sbsc_pkg::PAGE_RST;
            rif.mute_q <= sbsc_pkg::MUTE_RST;
            rif.range_q <= sbsc_pkg::RANGE_RST;
            rif.boost_q <= sbsc_pkg::BOOST_RST;
            rif.scan_q <= sbsc_pkg::SCAN_RST;
        end else begin
            if (wr_page) rif.page_q <= rif.wdata;
            if (wr_mute) rif.mute_q <= rif.wdata;
            if (wr_range) rif.range_q <= rif.wdata;
            if (wr_boost) rif.boost_q <= rif.wdata;
            if (wr_scan) rif.scan_q <= rif.wdata;
        end
    end
endmodule

// File: rtl/sbsc_scan_timer.sv
`timescale 1ns/10ps
module sbsc_scan_timer #(
    parameter logic [7:0][27:0] IVL_CYC = sbsc_pkg::IVL_CYC_DEF
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic power_in,
    input wire sbsc_pkg::sbsc_kind_e kind_in,
    input wire logic [2:0] ivl_in,
    input wire logic arm_in,
    input wire logic trig_in,
    input wire logic done_in,
    output logic start_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_GAP} sbsc_scan_e;
    sbsc_scan_e st_q;
    sbsc_scan_e st_d;
    logic [27:0] cnt_q;
    logic start_q;

    ////////////////////////////////////////////////////////////////
    // launch conditions per mode; the reserved mode never launches
    wire repeat_on = power_in && kind_in == sbsc_pkg::SBSC_REPEAT;
    wire one_go = kind_in == sbsc_pkg::SBSC_ONE_SHOT && arm_in;
    wire dsp_go = kind_in == sbsc_pkg::SBSC_DSP_TRIG && trig_in;
    wire go = power_in && (repeat_on || one_go || dsp_go);
    wire [27:0] gap_load = IVL_CYC[ivl_in] - 28'h1;
    wire gap_end = cnt_q == 28'h0;

    // next state; power loss drops any scan in progress
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (go) st_d = ST_BUSY;
            ST_BUSY: begin
                if (!power_in) st_d = ST_IDLE;
                else if (done_in) st_d = repeat_on ? ST_GAP : ST_IDLE;
            end
            ST_GAP: begin
                if (!repeat_on) st_d = ST_IDLE;
                else if (gap_end) st_d = ST_BUSY;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // gap counter loads on completion, counts down while waiting
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st_q <= ST_IDLE;
            cnt_q <= 28'h0;
            start_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= (st_d == ST_GAP && st_q != ST_GAP) ? gap_load : cnt_q - 28'h1;
            start_q <= st_d == ST_BUSY && st_q != ST_BUSY;
        end
    end

    assign start_out = start_q;
endmodule

// File: verif/tb_sbsc_config_regs.sv
`timescale 1ns/10ps
module tb_sbsc_config_regs;
    // short interval table so repeat gaps stay a few cycles long
    localparam logic [7:0][27:0] IVL_SIM = {28'd8, 28'd7, 28'd6, 28'd5,
        28'd4, 28'd3, 28'd2, 28'd1};
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic dsp_trigger_in = 1'b0;
    logic conv_done_in = 1'b0;
    logic [9:0] conv_data_in = 10'h000;
    logic [7:0] reg_rdata_out;
    logic reg_rvalid_out;
    logic current_channel_silence_out;
    logic voltage_channel_silence_out;
    logic [1:0] sense_range_select_out;
    logic boost_level_scheme_out;
    logic [2:0] monitor_adc_interval_out;
    logic readback_freeze_out;
    logic [1:0] monitor_adc_scan_kind_out;
    logic monitor_adc_power_out;
    logic conv_start_out;
    logic [9:0] readback_data_out;
    int error_cnt = 0;
    int n_checks = 0;
    int k;
    logic [2:0] c;
    logic [7:0] mv [4] = '{8'h01, 8'h02, 8'hfc, 8'hff};

    sbsc_config_regs #(.IVL_CYC(IVL_SIM)) dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
        .current_channel_silence_out(current_channel_silence_out),
        .voltage_channel_silence_out(voltage_channel_silence_out),
        .sense_range_select_out(sense_range_select_out),
        .boost_level_scheme_out(boost_level_scheme_out),
        .monitor_adc_interval_out(monitor_adc_interval_out),
        .readback_freeze_out(readback_freeze_out),
        .monitor_adc_scan_kind_out(monitor_adc_scan_kind_out),
        .monitor_adc_power_out(monitor_adc_power_out), .dsp_trigger_in(dsp_trigger_in),
        .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
        .conv_start_out(conv_start_out), .readback_data_out(readback_data_out)
    );

    // 250 MHz control clock
    initial begin
        forever #2 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and comparison helpers
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // register port: strobes rise and fall on falling edges, one idle cycle between
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        reg_wdata_in = ~d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        check("rvalid", reg_rvalid_out, 16'h1);
        check("rdata", reg_rdata_out, exp);
    endtask

    // bounded wait for a start pulse, k counts falling edges
    task automatic wait_start(output int n);
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
            if (n > 50) begin
                error_cnt++;
                complete_run();
            end
        end while (conv_start_out !== 1'b1);
    endtask

    // conversion result, data line scrambled once the pulse is over
    task automatic done(input logic [9:0] d);
        @(negedge clk_in);
        conv_done_in = 1'b1;
        conv_data_in = d;
        @(negedge clk_in);
        conv_done_in = 1'b0;
        conv_data_in = ~d;
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clk_in);
            check("no start", conv_start_out, 16'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk_in);
        rstn_in = 1'b1;
        // reset values of every register and field
        rd(8'h00, 8'h00);
        rd(8'h07, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h00);
        rd(8'h14, 8'h32);
        check("interval", monitor_adc_interval_out, 16'h3);
        check("kind", monitor_adc_scan_kind_out, 16'h1);
        check("power", monitor_adc_power_out, 16'h0);
        $display("test reset done");
        // mute bits and reserved bits
        foreach (mv[i]) begin
            wr(8'h07, mv[i]);
            check("isil", current_channel_silence_out, {15'h0, mv[i][1]});
            check("vsil", voltage_channel_silence_out, {15'h0, mv[i][0]});
            rd(8'h07, mv[i]);
        end
        $display("test mute done");
        // every range code, with the reserved bits set around it
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, 8'hf9 | {5'h00, i[1:0], 1'b0});
            check("range", sense_range_select_out, i[15:0]);
            rd(8'h08, 8'hf9 | {5'h00, i[1:0], 1'b0});
        end
        wr(8'h09, 8'h01);
        check("boost", boost_level_scheme_out, 16'h1);
        wr(8'h09, 8'hfe);
        check("boost", boost_level_scheme_out, 16'h0);
        rd(8'h09, 8'hfe);
        $display("test range boost done");
        // all interval and mode codes, freeze both ways, converter kept off
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(8'h14, {c[0], c, c[1], c[1:0], 1'b0});
            check("interval", monitor_adc_interval_out, {13'h0, c});
            check("freeze", readback_freeze_out, {15'h0, c[1]});
            check("kind", monitor_adc_scan_kind_out, {14'h0, c[1:0]});
            check("power", monitor_adc_power_out, 16'h0);
            rd(8'h14, {c[0], c, c[1], c[1:0], 1'b0});
        end
        $display("test scan fields done");
        // another page hides the bank, the selector stays reachable
        wr(8'h00, 8'h01);
        wr(8'h07, 8'h03);
        rd(8'h07, 8'h00);
        rd(8'h00, 8'h01);
        wr(8'h00, 8'h00);
        rd(8'h07, 8'hff);
        wr(8'h0a, 8'h5a);
        rd(8'h0a, 8'h00);
        $display("test paging done");
        // repeated scan: start, result, gap, freeze
        wr(8'h14, 8'h13);
        wait_start(k);
        check("power on start", k[15:0], 16'h1);
        done(10'h155);
        check("readback", readback_data_out, 16'h0155);
        wait_start(k);
        check("gap", k[15:0], IVL_SIM[1][15:0]);
        wr(8'h14, 8'h1b);
        done(10'h2aa);
        check("frozen", readback_data_out, 16'h0155);
        wait_start(k);
        wr(8'h14, 8'h13);
        done(10'h0f0);
        check("unfrozen", readback_data_out, 16'h00f0);
        wr(8'h14, 8'h12);
        quiet(12);
        $display("test repeat scan done");
        // triggered mode
        wr(8'h14, 8'h15);
        @(negedge clk_in);
        dsp_trigger_in = 1'b1;
        wait_start(k);
        dsp_trigger_in = 1'b0;
        check("trigger start", k[15:0], 16'h1);
        done(10'h3c3);
        wr(8'h14, 8'h10);
        // one-shot launches from the powering write
        wr(8'h14, 8'h11);
        wait_start(k);
        check("one shot start", k[15:0], 16'h1);
        done(10'h001);
        check("readback", readback_data_out, 16'h0001);
        quiet(12);
        // reserved mode never starts
        wr(8'h14, 8'h16);
        wr(8'h14, 8'h17);
        quiet(12);
        $display("test modes done");
        complete_run();
    end
endmodule
